// ==== hw/failover_defs.svh ====
// Register map, field positions and timing constants of the failover block
`ifndef FAILOVER_DEFS_SVH
`define FAILOVER_DEFS_SVH

`define FO_NUM_INST 4
`define FO_CTL_OFS 4'h0
`define FO_STS_OFS 4'h4
`define FO_TMR_OFS 4'h8
`define FO_INST_SPAN 8'h40
`define FO_IRQ_STS_ADDR 8'h40
`define FO_IRQ_MASK_ADDR 8'h44
`define FO_SWEVT_ADDR 8'h48

`define FO_CTL_SW_BIT 0
`define FO_CTL_PIN_EN_BIT 1
`define FO_CTL_POL_BIT 2
`define FO_CTL_TIM_EN_BIT 3
`define FO_STS_MODE_BIT 0
`define FO_STS_INIT_BIT 1
`define FO_STS_DONE_BIT 2
`define FO_SWEVT_FAILOVER_EVENT_FLAG_BIT 4

`define FO_REG_RESET 32'h0000_0000
`define FO_TICK_NS 1000
`define FO_CLK_NS 8

`define FO_RESP_OKAY 2'h0
`define FO_RESP_SLVERR 2'h2

`endif

// ==== hw/failover_pkg.sv ====
// Types shared by the failover block
package failover_pkg;

  typedef enum logic {
    MODE_PRIMARY = 1'b0,
    MODE_SECONDARY = 1'b1
  } fo_mode_e;

  typedef struct packed {
    logic timEn;
    logic pinPol;
    logic pinEn;
  } fo_ctl_s;

  typedef struct packed {
    logic primary;
    logic secondary;
  } fo_port_event_s;

endpackage : failover_pkg

// ==== hw/failover_trigger_control.sv ====
// Failover trigger control: four instances behind an AXI4-Lite slave
//
// Functional notes
// - Four independent instances, own registers and pin
// - Software trigger flips toward opposite mode
// - Software trigger bit always reads zero
// - Pin enable: each pin level change fails over
// - Active-high: rising secondary, falling primary
// - Active-low: falling secondary, rising primary
// - Timer enable lets watchdog expiry fail over
// - Status bit 0 shows new mode at once
// - Initiated flag sticky, write one clears
// - Completed flag set after side effects
// - Nothing sensitive: completed right after initiated
// - Writable 32-bit count, minus one per microsecond
// - Count holds at zero, no wrap
// - One-to-zero with timer enable fails over
// - Failover event drives port reconfiguration strobes
// - Global failover bit from unmasked change flags
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "failover_defs.svh"

module failover_trigger_control #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`FO_NUM_INST-1:0] failoverTriggerInput,
  input wire logic [`FO_NUM_INST-1:0] portSensitive,
  input wire logic [`FO_NUM_INST-1:0] sideEffectDone,
  output failover_pkg::fo_port_event_s [`FO_NUM_INST-1:0] portEvent,
  output logic [`FO_NUM_INST-1:0] currentFailoverMode,
  output logic failoverEventFlag,
  output logic irq
);
  import failover_pkg::*;

  localparam int N = `FO_NUM_INST;
  localparam int TICK_CYC = (`FO_TICK_NS + `FO_CLK_NS - 1) / `FO_CLK_NS;
  localparam int TICK_W = $clog2(TICK_CYC);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

  // ********************************************************
  // Byte-lane merge
  // ********************************************************
  function automatic logic [31:0] mergeStrb(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = newVal[b*8 +: 8];
      end
    end
    return res;
  endfunction : mergeStrb

  // ********************************************************
  // AXI4-Lite write channel
  // ********************************************************
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic awHeld_reg;
  logic wHeld_reg;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic doWrite;
  logic wrInstSel;
  logic wrKnown;

  assign doWrite = awHeld_reg && wHeld_reg && !bvalid_reg;
  assign wrInstSel = awAddr_reg < `FO_INST_SPAN;
  assign wrKnown = (wrInstSel && awAddr_reg[3:0] != 4'hC)
    || awAddr_reg == `FO_IRQ_STS_ADDR || awAddr_reg == `FO_IRQ_MASK_ADDR
    || awAddr_reg == `FO_SWEVT_ADDR;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      awready_reg <= 1'b0;
      awHeld_reg <= 1'b0;
      awAddr_reg <= '0;
    end
    else if (s_axi_awvalid && awready_reg)
    begin
      awready_reg <= 1'b0;
      awHeld_reg <= 1'b1;
      awAddr_reg <= s_axi_awaddr;
    end
    else
    begin
      if (doWrite)
        awHeld_reg <= 1'b0;
      if (!awHeld_reg && !bvalid_reg)
        awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wready_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      wData_reg <= `FO_REG_RESET;
      wStrb_reg <= '0;
    end
    else if (s_axi_wvalid && wready_reg)
    begin
      wready_reg <= 1'b0;
      wHeld_reg <= 1'b1;
      wData_reg <= s_axi_wdata;
      wStrb_reg <= s_axi_wstrb;
    end
    else
    begin
      if (doWrite)
        wHeld_reg <= 1'b0;
      if (!wHeld_reg && !bvalid_reg)
        wready_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `FO_RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wrKnown ? `FO_RESP_OKAY : `FO_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ********************************************************
  // Microsecond tick
  // ********************************************************
  logic [TICK_W-1:0] prescale_reg;
  logic tick_reg;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prescale_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= prescale_reg == TICK_LAST;
      prescale_reg <= (prescale_reg == TICK_LAST) ? '0 : prescale_reg + 1'b1;
    end
  end

  // ********************************************************
  // Failover instances
  // ********************************************************
  fo_ctl_s ctl_reg [N];
  logic [31:0] tmr_reg [N];
  logic [N-1:0] mode_reg;
  logic [N-1:0] initFlag_reg;
  logic [N-1:0] doneFlag_reg;
  logic [N-1:0] fire;
  logic [N-1:0] completeSet;
  fo_port_event_s [N-1:0] portEvent_reg;

  for (genvar i = 0; i < N; i++)
  begin : g_inst
    logic instSel;
    logic ctlWr;
    logic stsWr;
    logic tmrWr;
    logic swTrig;
    logic pinSync1_reg;
    logic pinSync2_reg;
    logic pinSync3_reg;
    logic pinLevel_reg;
    logic pinPrimed_reg;
    logic pinAgree;
    logic pinEdge;
    logic pinFire;
    logic tmrExpire;
    logic target;
    logic pending_reg;

    assign instSel = doWrite && wrInstSel && awAddr_reg[5:4] == 2'(i);
    assign ctlWr = instSel && awAddr_reg[3:0] == `FO_CTL_OFS;
    assign stsWr = instSel && awAddr_reg[3:0] == `FO_STS_OFS;
    assign tmrWr = instSel && awAddr_reg[3:0] == `FO_TMR_OFS;
    assign swTrig = ctlWr && wStrb_reg[0] && wData_reg[`FO_CTL_SW_BIT];

    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
        ctl_reg[i] <= '0;
      else if (ctlWr && wStrb_reg[0])
      begin
        ctl_reg[i].pinEn <= wData_reg[`FO_CTL_PIN_EN_BIT];
        ctl_reg[i].pinPol <= wData_reg[`FO_CTL_POL_BIT];
        ctl_reg[i].timEn <= wData_reg[`FO_CTL_TIM_EN_BIT];
      end
    end

    // Second and third stages must agree, third gives the level; first stage feeds only the second
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        pinSync1_reg <= 1'b0;
        pinSync2_reg <= 1'b0;
        pinSync3_reg <= 1'b0;
      end
      else
      begin
        pinSync1_reg <= failoverTriggerInput[i];
        pinSync2_reg <= pinSync1_reg;
        pinSync3_reg <= pinSync2_reg;
      end
    end

    assign pinAgree = pinSync2_reg == pinSync3_reg;
    // First settled level after reset is only learned, never an edge
    assign pinEdge = pinPrimed_reg && pinAgree && pinSync3_reg != pinLevel_reg;

    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        pinLevel_reg <= 1'b0;
        pinPrimed_reg <= 1'b0;
      end
      else if (pinAgree)
      begin
        pinLevel_reg <= pinSync3_reg;
        pinPrimed_reg <= 1'b1;
      end
    end

    assign pinFire = pinEdge && ctl_reg[i].pinEn;
    // Rising edge goes secondary unless polarity is inverted
    assign target = pinFire ? (pinSync3_reg ^ ctl_reg[i].pinPol) : !mode_reg[i];

    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
        tmr_reg[i] <= `FO_REG_RESET;
      else if (tmrWr)
        tmr_reg[i] <= mergeStrb(tmr_reg[i], wData_reg, wStrb_reg);
      else if (tick_reg && tmr_reg[i] != '0)
        tmr_reg[i] <= tmr_reg[i] - 32'h0000_0001;
    end

    // Only a counted step from one fires; a written zero does not
    assign tmrExpire = tick_reg && !tmrWr && tmr_reg[i] == 32'h0000_0001
      && ctl_reg[i].timEn;
    assign fire[i] = swTrig || pinFire || tmrExpire;

    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
        mode_reg[i] <= MODE_PRIMARY;
      else if (fire[i])
        mode_reg[i] <= target;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
        pending_reg <= 1'b0;
      else if (fire[i])
        pending_reg <= 1'b1;
      else if (completeSet[i])
        pending_reg <= 1'b0;
    end

    assign completeSet[i] = pending_reg && !fire[i]
      && (!portSensitive[i] || sideEffectDone[i]);

    // Set beats a same-cycle write-one clear
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        initFlag_reg[i] <= 1'b0;
        doneFlag_reg[i] <= 1'b0;
      end
      else
      begin
        initFlag_reg[i] <= fire[i] || (initFlag_reg[i]
          && !(stsWr && wStrb_reg[0] && wData_reg[`FO_STS_INIT_BIT]));
        doneFlag_reg[i] <= completeSet[i] || (doneFlag_reg[i]
          && !(stsWr && wStrb_reg[0] && wData_reg[`FO_STS_DONE_BIT]));
      end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
        portEvent_reg[i] <= '0;
      else
      begin
        portEvent_reg[i].primary <= fire[i] && target == MODE_PRIMARY;
        portEvent_reg[i].secondary <= fire[i] && target == MODE_SECONDARY;
      end
    end
  end

  assign portEvent = portEvent_reg;
  assign currentFailoverMode = mode_reg;

  // ********************************************************
  // Interrupt status, mask and global event
  // ********************************************************
  logic [2*N-1:0] irqSts_reg;
  logic [2*N-1:0] irqMask_reg;
  logic irq_reg;
  logic foverEvt_reg;
  logic irqStsWr;
  logic irqMaskWr;
  logic [2*N-1:0] irqClr;

  assign irqStsWr = doWrite && awAddr_reg == `FO_IRQ_STS_ADDR;
  assign irqMaskWr = doWrite && awAddr_reg == `FO_IRQ_MASK_ADDR;
  assign irqClr = irqStsWr && wStrb_reg[0] ? wData_reg[2*N-1:0] : '0;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      irqSts_reg <= '0;
    else
      irqSts_reg <= {completeSet, fire} | (irqSts_reg & ~irqClr);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      irqMask_reg <= '0;
    else if (irqMaskWr && wStrb_reg[0])
      irqMask_reg <= wData_reg[2*N-1:0];
  end

  // Level output follows the flags a cycle later
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_reg <= 1'b0;
      foverEvt_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= |(irqSts_reg & irqMask_reg);
      foverEvt_reg <= |(irqSts_reg & irqMask_reg);
    end
  end

  assign irq = irq_reg;
  assign failoverEventFlag = foverEvt_reg;

  // ********************************************************
  // AXI4-Lite read channel
  // ********************************************************
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdMux;
  logic rdErr;
  logic [1:0] rdInst;

  assign rdInst = s_axi_araddr[5:4];

  always_comb
  begin
    rdMux = `FO_REG_RESET;
    rdErr = 1'b0;
    if (s_axi_araddr < `FO_INST_SPAN)
    begin
      case (s_axi_araddr[3:0])
        `FO_CTL_OFS:
        begin
          rdMux[`FO_CTL_SW_BIT] = 1'b0;
          rdMux[`FO_CTL_PIN_EN_BIT] = ctl_reg[rdInst].pinEn;
          rdMux[`FO_CTL_POL_BIT] = ctl_reg[rdInst].pinPol;
          rdMux[`FO_CTL_TIM_EN_BIT] = ctl_reg[rdInst].timEn;
        end
        `FO_STS_OFS:
        begin
          rdMux[`FO_STS_MODE_BIT] = mode_reg[rdInst];
          rdMux[`FO_STS_INIT_BIT] = initFlag_reg[rdInst];
          rdMux[`FO_STS_DONE_BIT] = doneFlag_reg[rdInst];
        end
        `FO_TMR_OFS:
          rdMux = tmr_reg[rdInst];
        default:
          rdErr = 1'b1;
      endcase
    end
    else if (s_axi_araddr == `FO_IRQ_STS_ADDR)
      rdMux[2*N-1:0] = irqSts_reg;
    else if (s_axi_araddr == `FO_IRQ_MASK_ADDR)
      rdMux[2*N-1:0] = irqMask_reg;
    else if (s_axi_araddr == `FO_SWEVT_ADDR)
      rdMux[`FO_SWEVT_FAILOVER_EVENT_FLAG_BIT] = foverEvt_reg;
    else
      rdErr = 1'b1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= `FO_REG_RESET;
      rresp_reg <= `FO_RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_reg)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rdErr ? `FO_REG_RESET : rdMux;
      rresp_reg <= rdErr ? `FO_RESP_SLVERR : `FO_RESP_OKAY;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
    end
    else if (!rvalid_reg)
    begin
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule : failover_trigger_control

// ==== sim/failover_pin_source.sv ====
// External trigger source model driving the four failover pins
`timescale 1ns/10ps

module failover_pin_source (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] drive,
  output logic [3:0] pins
);
  // ***
  // Pin drive
  // ***
  // Skewed off the clock edge: pins are asynchronous to the core
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pins <= 4'h0;
    else
      pins <= #3 drive;
  end
endmodule : failover_pin_source

// ==== sim/failover_trigger_control_checker.sv ====
// Concurrent checks on bus answers and failover event outputs
`timescale 1ns/10ps
`include "failover_defs.svh"

module failover_trigger_control_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire failover_pkg::fo_port_event_s [3:0] portEvent,
  input wire logic [3:0] currentFailoverMode,
  input wire logic failoverEventFlag,
  input wire logic irq
);
  import failover_pkg::*;
  // ***
  // Properties
  // ***
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer missing");
  property p_wr_refused;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_refused: assert property (p_wr_refused) else $error("write taken during answer");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
  property p_unmapped_zero;
    s_axi_rvalid && s_axi_rresp == `FO_RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read data");
  property p_irq_flag;
    irq == failoverEventFlag;
  endproperty
  a_irq_flag: assert property (p_irq_flag) else $error("irq differs from flag");
  property p_sec_event;
    portEvent[0].secondary |-> currentFailoverMode[0] && !portEvent[0].primary;
  endproperty
  a_sec_event: assert property (p_sec_event) else $error("secondary event mode");
  property p_pri_event;
    portEvent[0].primary |-> !currentFailoverMode[0];
  endproperty
  a_pri_event: assert property (p_pri_event) else $error("primary event mode");
  property p_change_event;
    $changed(currentFailoverMode[0]) |-> portEvent[0] != 2'h0;
  endproperty
  a_change_event: assert property (p_change_event) else $error("mode change no event");
  property p_event_pulse;
    portEvent[0] != 2'h0 |=> portEvent[0] == 2'h0;
  endproperty
  a_event_pulse: assert property (p_event_pulse) else $error("event not a pulse");
  c_sec: cover property (portEvent[0].secondary);
  c_pri: cover property (portEvent[0].primary);
  c_irq: cover property ($rose(irq));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == `FO_RESP_SLVERR);
endmodule : failover_trigger_control_checker

bind failover_trigger_control failover_trigger_control_checker chk (.clk, .nrst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp,
  .portEvent, .currentFailoverMode, .failoverEventFlag, .irq);

// ==== sim/test_failover_trigger_control.sv ====
// Self-checking testbench of the failover trigger block
`timescale 1ns/10ps
`include "failover_defs.svh"

module test_failover_trigger_control;
  import failover_pkg::*;
  // ***
  // Stimulus and wiring
  // ***
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [7:0] awAddr = 8'h0;
  logic [7:0] arAddr = 8'h0;
  logic [31:0] wData = 32'h0;
  logic awValid = 1'h0;
  logic wValid = 1'h0;
  logic arValid = 1'h0;
  logic [3:0] pinDrive = 4'h0;
  logic [3:0] portSens = 4'h0;
  logic [3:0] sideDone = 4'h0;
  logic awReady, wReady, bValid, arReady, rValid, evtFlag, irq;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  logic [3:0] mode, pins;
  fo_port_event_s [3:0] portEvt;
  int failCount = 0;
  int checked = 0;
  int cycle = 0;

  always #4 clk = ~clk;
  always @(posedge clk) cycle <= cycle + 1;

  failover_trigger_control DUT (.clk(clk), .nrst(nrst), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(1'h1), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(1'h1),
    .failoverTriggerInput(pins), .portSensitive(portSens), .sideEffectDone(sideDone),
    .portEvent(portEvt), .currentFailoverMode(mode), .failoverEventFlag(evtFlag), .irq(irq));
  failover_pin_source PINS (.clk(clk), .nrst(nrst), .drive(pinDrive), .pins(pins));

  // ***
  // Bus and compare tasks
  // ***
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failCount++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Ready lines are tied high, so the answer is taken at the edge it is seen
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `FO_RESP_OKAY);
    awAddr <= a;
    wData <= d;
    awValid <= 1'h1;
    wValid <= 1'h1;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (awReady) awValid <= 1'h0;
      if (wReady) wValid <= 1'h0;
      if (bValid) break;
    end
    // A write answer that never came counts as a mismatch
    check($sformatf("bvalid %h", a), 32'(bValid), 32'h1);
    check($sformatf("bresp %h", a), 32'(bResp), 32'(er));
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = `FO_RESP_OKAY);
    arAddr <= a;
    arValid <= 1'h1;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (arReady) arValid <= 1'h0;
      if (rValid) break;
    end
    check($sformatf("rvalid %h", a), 32'(rValid), 32'h1);
    check($sformatf("rresp %h", a), 32'(rResp), 32'(er));
    check($sformatf("rdata %h", a), rData, exp);
  endtask : rd

  // ***
  // Scenarios
  // ***
  task t_reset;
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(16 * i + `FO_CTL_OFS), `FO_REG_RESET);
      rd(8'(16 * i + `FO_STS_OFS), `FO_REG_RESET);
      rd(8'(16 * i + `FO_TMR_OFS), `FO_REG_RESET);
    end
    rd(8'h0C, 32'h0, `FO_RESP_SLVERR);
    wr(8'h4C, 32'hF, `FO_RESP_SLVERR);
  endtask : t_reset

  task t_timer;
    int t0;
    wr(8'h08, 32'h1);
    repeat (260) @(posedge clk);
    check("mode0 timer off", 32'(mode), 32'h0);
    rd(8'h08, 32'h0);
    wr(8'h00, 32'h8);
    wr(8'h08, 32'h2);
    for (int n = 0; n < 300 && !mode[0]; n++) @(posedge clk);
    check("mode0 expiry", 32'(mode), 32'h1);
    t0 = cycle;
    wr(8'h08, 32'h2);
    rd(8'h08, 32'h2);
    for (int n = 0; n < 300 && mode[0]; n++) @(posedge clk);
    check("expiry interval", 32'(cycle - t0), 32'd250);
    repeat (260) @(posedge clk);
    check("mode0 no wrap", 32'(mode), 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h04, 32'h6);
    // Leave no sticky flags behind for the later interrupt checks
    wr(8'h04, 32'h6);
    wr(8'h40, 32'h11);
    rd(8'h40, 32'h0);
    wr(8'h00, 32'h0);
  endtask : t_timer

  task t_soft;
    wr(8'h10, 32'h1);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h7);
    check("mode soft", 32'(mode), 32'h2);
    rd(8'h40, 32'h22);
    check("irq masked", 32'(irq), 32'h0);
    wr(8'h44, 32'h2);
    repeat (3) @(posedge clk);
    check("irq unmasked", 32'(evtFlag), 32'h1);
    rd(8'h48, 32'h10);
    wr(8'h40, 32'h22);
    repeat (3) @(posedge clk);
    check("irq cleared", 32'(irq), 32'h0);
    wr(8'h14, 32'h6);
    rd(8'h14, 32'h1);
    wr(8'h10, 32'h1);
    rd(8'h14, 32'h6);
    wr(8'h14, 32'h6);
    wr(8'h44, 32'h0);
  endtask : t_soft

  // Fixed waits cover the synchroniser with a wide margin
  task pin_step(input logic lvl, input logic [31:0] exp);
    pinDrive[2] <= lvl;
    repeat (20) @(posedge clk);
    check("mode2 pin", 32'(mode[2]), exp);
  endtask : pin_step

  task t_pin;
    wr(8'h20, 32'h2);
    pin_step(1'h1, 32'h1);
    pin_step(1'h0, 32'h0);
    wr(8'h20, 32'h6);
    pin_step(1'h1, 32'h0);
    pin_step(1'h0, 32'h1);
    wr(8'h20, 32'h0);
    wr(8'h24, 32'h6);
    pin_step(1'h1, 32'h1);
    rd(8'h24, 32'h1);
  endtask : t_pin

  task t_sens;
    portSens[3] <= 1'h1;
    wr(8'h30, 32'h1);
    rd(8'h34, 32'h3);
    sideDone[3] <= 1'h1;
    @(posedge clk);
    sideDone[3] <= 1'h0;
    repeat (2) @(posedge clk);
    rd(8'h34, 32'h7);
    portSens[3] <= 1'h0;
  endtask : t_sens

  // ***
  // Sequence and verdict
  // ***
  task print_verdict;
    $display("comparisons %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    t_reset();
    t_timer();
    t_soft();
    t_pin();
    t_sens();
    print_verdict();
  end

  // Run needs about 1300 cycles; reaching the limit of 20000 cycles means a hang
  initial
  begin
    #160000;
    failCount++;
    print_verdict();
  end
endmodule : test_failover_trigger_control
